// File: ers_pkg.sv
// Package: constants, register map and carriers for the emergency run block
package ers_pkg;

    // Register indices (word addresses)
    localparam logic [3:0] ADDR_MODE     = 4'h0;
    localparam logic [3:0] ADDR_FREQ     = 4'h1;
    localparam logic [3:0] ADDR_DIR      = 4'h2;
    localparam logic [3:0] ADDR_COUNT    = 4'h3;
    localparam logic [3:0] ADDR_TERMFN   = 4'h4;
    localparam logic [3:0] ADDR_WAIT     = 4'h5;
    localparam logic [3:0] ADDR_VSEL     = 4'h6;
    localparam logic [3:0] ADDR_STATUS   = 4'h7;

    // Mode selection encodings
    localparam logic [1:0] MODE_OFF      = 2'h0;
    localparam logic [1:0] MODE_TEST     = 2'h1;
    localparam logic [1:0] MODE_RUN      = 2'h2;

    // Terminal function code that arms emergency run
    localparam logic [5:0] TERM_FN_CODE  = 6'h33;
    localparam logic [5:0] TERM_FN_MAX   = 6'h36;

    // Frequency limit and reset values
    localparam logic [7:0] FREQ_MAX      = 8'h3C;
    localparam logic [7:0] FREQ_RESET    = 8'h00;
    localparam logic [15:0] WAIT_RESET   = 16'h0001;

    // Restart wait unit: 1 ms tick at 20 MHz
    localparam int CLK_HZ        = 20_000_000;
    localparam int WAIT_UNIT_US  = 1000;
    localparam int TICK_CYCLES   = CLK_HZ / 1_000_000 * WAIT_UNIT_US;

    // Status bit positions
    localparam int ST_ACTIVE   = 0;
    localparam int ST_TEST     = 1;
    localparam int ST_STOPPED  = 2;
    localparam int ST_WAITING  = 3;
    localparam int ST_OVM      = 4;

    // Fault trip inputs, grouped by handling class
    typedef struct packed {
        logic out_block;    // Output block input
        logic ext_trip;
        logic under_volt;
        logic drv_heat;
        logic drv_ovld;
        logic load_ovld;
        logic thermal;
        logic phase_loss;
        logic mot_ovld;
        logic fan;
        logic no_motor;
        logic other_minor;
        logic over_volt;
        logic overcurrent_level_one;
        logic ground;
        logic hw_diag;
        logic arm_short;
    } ers_trips_t;

    // Register bus request
    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } ers_bus_t;

    // Drive commands issued to the ramp and output stage
    typedef struct packed {
        logic       override;     // Emergency references in force
        logic [7:0] freq;
        logic       dir;
        logic       ramp_up;      // Use ramp_up_time
        logic       ramp_down;    // Use ramp_down_time
        logic       run;
        logic       reset_pulse;  // One-cycle fault reset request
        logic       halt;         // Stop state: fatal trip, or major trip in test variant
    } ers_cmd_t;

endpackage : ers_pkg

// File: ers_top.sv
// Emergency run supervisor with extended voltage range selection
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
// Overview of operation
// - Enter only with mode 2 (mode 1 for the test variant) and terminal code 51
// - Normal emergency run adds one to tally
// - Test variant: no retries, tally unchanged
// - Suppress minor trips, retry major trips unlimited
// - Wait restart delay between retry attempts
// - Emergency frequency 0-60 overrides other references
// - Direction from dedicated one-bit setting
// - Ramp up on entry, ramp down on release
// - Record suppressed faults, mask trip outputs
// - Suppressed set lists twelve minor trip kinds
// - Overvoltage, overcurrent one, ground fault keep retrying
// - Hardware diagnostic or arm short stops operation
// - Select 0 clamps linear, yes allows overmodulation
// - No overmodulation while input exceeds output voltage
//
// Arming needs mode, terminal code and terminal level together;
// losing any one of them outside the stop state counts as a release of the terminal.
// The tally only counts fresh entries from idle in full emergency
// run, so retries and re-arming during ramp down leave it alone.
// The tally saturates instead of wrapping, so a used unit never
// reads back as unused; software has no write path to it.
// Minor trips are not decoded for control at all: they only reach
// the trip history, which keeps recording every trip class.
// A major trip parks the supervisor in the wait state with the
// emergency references still in force and the run command dropped.
// The wait is counted in whole milliseconds from a tick that
// restarts at every entry, so each retry waits the full delay.
// A delay of zero is served as one millisecond: restarting with no
// gap would hammer the output stage while the fault persists.
// Each retry ends with a one-cycle fault reset pulse beside run.
// Fatal trips hold the stop state until the terminal is released,
// so a held terminal cannot restart into a shorted bridge arm.
// The test variant stops on the first major trip instead.
module ers_top #(
    parameter int COUNT_W = 16
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              arst_n,
    // Register port
    input  wire ers_pkg::ers_bus_t bus,
    output logic [15:0]            rdata,
    // Input terminal level; its function code is the ADDR_TERMFN register
    input  wire logic              term_in,
    // Fault trip inputs
    input  wire ers_pkg::ers_trips_t trips,
    input  wire logic              trip_normal, // Trip outputs, normal use
    // Voltage comparison from the output stage
    input  wire logic              vin_above_vout,
    // Drive commands
    output ers_pkg::ers_cmd_t      cmd,
    // Trip history and trip output pins
    output logic                   hist_log,
    output logic                   trip_out,
    // Voltage range
    output logic                   ovm_enable
);

    // Refuse tally widths the read port cannot show
    if (COUNT_W < 1 || COUNT_W > 16) begin : g_bad_count_w
        $error("COUNT_W must be 1..16");
    end

    // Register index match, shared by every write decode
    function automatic logic is_reg(input logic [3:0] a,
                                    input logic [3:0] idx);
        return a == idx;
    endfunction : is_reg

    typedef enum logic [2:0] {
        ERS_IDLE, ERS_RUN, ERS_WAIT, ERS_STOP, ERS_RAMPDN
    } ers_state_t;

    // Configuration registers
    logic [1:0]         mode;
    logic [7:0]         freq;
    logic               dir;
    logic [5:0]         term_fn;
    logic [15:0]        wait_ms;
    logic               vsel;
    logic [COUNT_W-1:0] tally;
    ers_state_t         state;
    ers_state_t         next_state;
    logic [15:0]        wait_cnt;
    logic [15:0]        tick_cnt;

    // Trip classes
    wire minor_trip = trips.out_block | trips.ext_trip | trips.under_volt
                    | trips.drv_heat | trips.drv_ovld | trips.load_ovld
                    | trips.thermal | trips.phase_loss | trips.mot_ovld
                    | trips.fan | trips.no_motor | trips.other_minor;
    wire major_trip = trips.over_volt | trips.overcurrent_level_one
                    | trips.ground;
    wire fatal_trip = trips.hw_diag | trips.arm_short;
    wire any_trip   = minor_trip | major_trip | fatal_trip;

    // Arming decode
    wire fn_ok   = (term_fn == ers_pkg::TERM_FN_CODE);
    wire arm_run = (mode == ers_pkg::MODE_RUN) & fn_ok & term_in;
    wire arm_tst = (mode == ers_pkg::MODE_TEST) & fn_ok & term_in;
    wire armed   = arm_run | arm_tst;
    wire test_q  = (mode == ers_pkg::MODE_TEST);
    wire active  = (state == ERS_RUN) | (state == ERS_WAIT);

    // Register decode
    wire wr_mode = bus.wr & is_reg(bus.addr, ers_pkg::ADDR_MODE);
    wire wr_freq = bus.wr & is_reg(bus.addr, ers_pkg::ADDR_FREQ);
    wire wr_dir  = bus.wr & is_reg(bus.addr, ers_pkg::ADDR_DIR);
    wire wr_fn   = bus.wr & is_reg(bus.addr, ers_pkg::ADDR_TERMFN);
    wire wr_wait = bus.wr & is_reg(bus.addr, ers_pkg::ADDR_WAIT);
    wire wr_vsel = bus.wr & is_reg(bus.addr, ers_pkg::ADDR_VSEL);
    wire tick    = (tick_cnt == 16'(ers_pkg::TICK_CYCLES - 1));
    wire wait_done = tick & (wait_cnt <= 16'h0001);
    wire cnt_full = &tally;

    // Status word, one flag per package position
    logic [15:0] status_word;
    always_comb begin
        status_word                      = 16'h0000;
        status_word[ers_pkg::ST_ACTIVE]  = active;
        status_word[ers_pkg::ST_TEST]    = test_q & active;
        status_word[ers_pkg::ST_STOPPED] = (state == ERS_STOP);
        status_word[ers_pkg::ST_WAITING] = (state == ERS_WAIT);
        status_word[ers_pkg::ST_OVM]     = ovm_enable;
    end

    // Read mux
    logic [15:0] rd_mux;
    always_comb begin
        unique case (bus.addr)
            ers_pkg::ADDR_MODE:   rd_mux = {14'h0000, mode};
            ers_pkg::ADDR_FREQ:   rd_mux = {8'h00, freq};
            ers_pkg::ADDR_DIR:    rd_mux = {15'h0000, dir};
            ers_pkg::ADDR_COUNT:  rd_mux = 16'(tally);
            ers_pkg::ADDR_TERMFN: rd_mux = {10'h000, term_fn};
            ers_pkg::ADDR_WAIT:   rd_mux = wait_ms;
            ers_pkg::ADDR_VSEL:   rd_mux = {15'h0000, vsel};
            ers_pkg::ADDR_STATUS: rd_mux = status_word;
            default:              rd_mux = 16'h0000;
        endcase
    end

    // Next state
    always_comb begin
        next_state = state;
        unique case (state)
            ERS_IDLE:   if (armed) next_state = ERS_RUN;
            ERS_RUN: begin
                if (fatal_trip)
                    next_state = ERS_STOP;
                else if (!armed)
                    next_state = ERS_RAMPDN;
                else if (major_trip)
                    next_state = test_q ? ERS_STOP : ERS_WAIT;
            end
            ERS_WAIT: begin
                if (fatal_trip)
                    next_state = ERS_STOP;
                else if (!armed)
                    next_state = ERS_RAMPDN;
                else if (wait_done)
                    next_state = ERS_RUN;
            end
            ERS_RAMPDN: next_state = armed ? ERS_RUN : ERS_IDLE;
            ERS_STOP:   if (!term_in) next_state = ERS_IDLE;
            default:    next_state = ERS_IDLE;
        endcase
    end

    // Configuration writes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode    <= ers_pkg::MODE_OFF;
            freq    <= ers_pkg::FREQ_RESET;
            dir     <= 1'b0;
            term_fn <= 6'h00;
            wait_ms <= ers_pkg::WAIT_RESET;
            vsel    <= 1'b0;
        end else begin
            if (wr_mode && bus.wdata[1:0] <= ers_pkg::MODE_RUN)
                mode <= bus.wdata[1:0];
            if (wr_freq && bus.wdata[7:0] <= ers_pkg::FREQ_MAX)
                freq <= bus.wdata[7:0];
            if (wr_dir)
                dir <= bus.wdata[0];
            if (wr_fn && bus.wdata[5:0] <= ers_pkg::TERM_FN_MAX)
                term_fn <= bus.wdata[5:0];
            if (wr_wait)
                wait_ms <= bus.wdata;
            if (wr_vsel)
                vsel <= bus.wdata[0];
        end
    end

    // State, restart wait timer and tally
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state    <= ERS_IDLE;
            wait_cnt <= 16'h0000;
            tick_cnt <= 16'h0000;
            tally    <= '0;
        end else begin
            state    <= next_state;
            tick_cnt <= (state != ERS_WAIT || tick) ? 16'h0000
                                                    : tick_cnt + 16'h0001;
            if (state == ERS_RUN && next_state == ERS_WAIT)
                wait_cnt <= wait_ms;
            else if (state == ERS_WAIT && tick && wait_cnt != 16'h0000)
                wait_cnt <= wait_cnt - 16'h0001;
            if (state == ERS_IDLE && arm_run && !cnt_full)
                tally <= tally + COUNT_W'(1);
        end
    end

    // Registered outputs
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata      <= 16'h0000;
            cmd        <= '0;
            hist_log   <= 1'b0;
            trip_out   <= 1'b0;
            ovm_enable <= 1'b0;
        end else begin
            rdata           <= bus.rd ? rd_mux : 16'h0000;
            cmd.override    <= (next_state == ERS_RUN)
                             | (next_state == ERS_WAIT)
                             | (next_state == ERS_RAMPDN);
            cmd.freq        <= freq;
            cmd.dir         <= dir;
            cmd.ramp_up     <= (next_state == ERS_RUN);
            cmd.ramp_down   <= (next_state == ERS_RAMPDN);
            cmd.run         <= (next_state == ERS_RUN);
            cmd.reset_pulse <= (state == ERS_WAIT) & (next_state == ERS_RUN);
            cmd.halt        <= (next_state == ERS_STOP);
            hist_log        <= any_trip;
            trip_out        <= active ? 1'b0 : trip_normal;
            ovm_enable      <= vsel & ~vin_above_vout;
        end
    end

endmodule : ers_top

// File: ers_top_chk.sv
// Checker for the emergency run supervisor ports
`timescale 1ns/1ns
module ers_chk #(
    parameter int COUNT_W = 16
) (
    // Clock and reset
    input wire logic                clk,
    input wire logic                arst_n,
    // Register port
    input wire ers_pkg::ers_bus_t   bus,
    input wire logic [15:0]         rdata,
    // Terminal, trips and voltage
    input wire logic                term_in,
    input wire ers_pkg::ers_trips_t trips,
    input wire logic                trip_normal,
    input wire logic                vin_above_vout,
    // Supervisor outputs
    input wire ers_pkg::ers_cmd_t   cmd,
    input wire logic                hist_log,
    input wire logic                trip_out,
    input wire logic                ovm_enable
);
    localparam int MIN_WAIT = 19998;
    logic [15:0] wait_cnt;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Length of the current retry wait
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) wait_cnt <= 16'h0000;
        else if (cmd.override && !cmd.run && !cmd.ramp_down && !cmd.halt)
            wait_cnt <= wait_cnt + 16'h0001;
        else wait_cnt <= 16'h0000;
    end
    // Ramp down for one cycle, then idle
    sequence s_ramp_stop;
        cmd.ramp_down && !cmd.run ##1 !cmd.override;
    endsequence
    a_arm_entry: assert property ($rose(cmd.ramp_up) |-> $past(term_in))
        else $error("run began without the terminal");
    a_release_ramp: assert property (cmd.run && !term_in &&
        !trips.hw_diag && !trips.arm_short |=> s_ramp_stop)
        else $error("release did not ramp down and stop");
    a_minor_kept: assert property (cmd.run && term_in &&
        trips[4:0] == 5'h00 |=> cmd.run) else $error("minor trip stopped run");
    a_major_halt: assert property (cmd.run && term_in && trips.over_volt &&
        !trips.hw_diag && !trips.arm_short |=> !cmd.run)
        else $error("major trip left run on");
    a_fatal_stop: assert property (cmd.run && term_in &&
        (trips.hw_diag || trips.arm_short) |=> cmd.halt && !cmd.run)
        else $error("fatal trip did not stop");
    a_retry_wait: assert property ($rose(cmd.reset_pulse) |->
        $past(wait_cnt) >= MIN_WAIT) else $error("retry came too early");
    a_trip_mask: assert property (cmd.run [*2] |-> !trip_out)
        else $error("trip output shown during run");
    a_hist_log: assert property ($past(arst_n) |->
        hist_log == (|$past(trips))) else $error("trip not recorded");
    a_ovm_gate: assert property (ovm_enable |-> !$past(vin_above_vout))
        else $error("overmodulation with high input");
    a_freq_range: assert property (cmd.override |->
        cmd.freq <= ers_pkg::FREQ_MAX) else $error("frequency above range");
endmodule : ers_chk
bind ers_top ers_chk #(.COUNT_W(COUNT_W)) ers_chk_inst (.clk(clk),
    .arst_n(arst_n), .bus(bus), .rdata(rdata), .term_in(term_in),
    .trips(trips), .trip_normal(trip_normal), .cmd(cmd),
    .vin_above_vout(vin_above_vout), .hist_log(hist_log),
    .trip_out(trip_out), .ovm_enable(ovm_enable));

// File: ers_plant.sv
// Far side model: fault detectors and output stage
`timescale 1ns/1ns
module ers_plant (
    // Clock
    input  wire logic                clk,
    // Requests from the bench
    input  wire ers_pkg::ers_trips_t fault_req,
    input  wire logic                hv_req,
    // Levels seen by the supervisor
    output ers_pkg::ers_trips_t      trips,
    output logic                     vin_above_vout
);
    // Detectors settle one cycle after the condition
    always_ff @(posedge clk) begin
        trips          <= fault_req;
        vin_above_vout <= hv_req;
    end
endmodule : ers_plant

// File: tb_emergency_run_supervisor.sv
// Self-checking bench for the emergency run supervisor
`timescale 1ns/1ns
module tb_emergency_run_supervisor;
    logic                clk = 1'b0;
    logic                arst_n = 1'b0;
    ers_pkg::ers_bus_t   bus = '0;
    logic [15:0]         rdata;
    logic                term_in = 1'b0;
    logic                trip_normal = 1'b0;
    logic                hv_req = 1'b0;
    ers_pkg::ers_trips_t fault_req = '0;
    ers_pkg::ers_trips_t trips;
    ers_pkg::ers_cmd_t   cmd;
    logic                hist_log, trip_out, ovm_enable, vin_above_vout;
    logic                seen;
    int                  num_errors = 0;
    int                  num_checks = 0;
    int                  n;
    // 50 ns clock
    always #25 clk = ~clk;
    ers_top ers_top_inst (.clk(clk), .arst_n(arst_n), .bus(bus),
        .rdata(rdata), .term_in(term_in), .trips(trips),
        .trip_normal(trip_normal), .vin_above_vout(vin_above_vout),
        .cmd(cmd), .hist_log(hist_log), .trip_out(trip_out),
        .ovm_enable(ovm_enable));
    ers_plant ers_plant_inst (.clk(clk), .fault_req(fault_req),
        .hv_req(hv_req), .trips(trips), .vin_above_vout(vin_above_vout));
    task automatic end_of_test;
        if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    task automatic tick(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : tick
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_bit(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask : chk_bit
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask : rd
    task automatic wait_run(input logic v);
        for (n = 0; n < 40 && cmd.run !== v; n++) tick(1);
        if (n == 40) begin
            num_errors++;
            end_of_test();
        end
    endtask : wait_run
    // Reset values and refused writes
    task automatic t_regs;
        rd(ers_pkg::ADDR_WAIT, 16'h0001);
        wr(ers_pkg::ADDR_MODE, 16'h0003);
        rd(ers_pkg::ADDR_MODE, 16'h0000);
        wr(ers_pkg::ADDR_FREQ, 16'h003D);
        rd(ers_pkg::ADDR_FREQ, 16'h0000);
        wr(ers_pkg::ADDR_COUNT, 16'h0005);
        rd(ers_pkg::ADDR_COUNT, 16'h0000);
        rd(4'h8, 16'h0000);
    endtask : t_regs
    // Arming conditions, references, minor and major trips, release
    task automatic t_run;
        wr(ers_pkg::ADDR_FREQ, 16'h003C);
        wr(ers_pkg::ADDR_DIR, 16'h0001);
        wr(ers_pkg::ADDR_TERMFN, 16'h0033);
        term_in <= 1'b1;
        tick(5);
        chk_bit(cmd.run, 1'b0);
        wr(ers_pkg::ADDR_TERMFN, 16'h0032);
        wr(ers_pkg::ADDR_MODE, 16'h0002);
        tick(5);
        chk_bit(cmd.run, 1'b0);
        wr(ers_pkg::ADDR_TERMFN, 16'h0033);
        wait_run(1'b1);
        chk({8'h00, cmd.freq}, 16'h003C);
        chk_bit(cmd.dir, 1'b1);
        chk_bit(cmd.ramp_up, 1'b1);
        rd(ers_pkg::ADDR_COUNT, 16'h0001);
        trip_normal <= 1'b1;
        fault_req <= 17'h1_FFE0;
        tick(4);
        chk_bit(cmd.run, 1'b1);
        chk_bit(trip_out, 1'b0);
        chk_bit(hist_log, 1'b1);
        fault_req <= 17'h0_0010;
        tick(4);
        chk_bit(cmd.run, 1'b0);
        fault_req <= '0;
        for (n = 0; n < 25000 && cmd.reset_pulse !== 1'b1; n++) tick(1);
        chk_bit(n >= 19990 && n < 25000, 1'b1);
        if (n == 25000) end_of_test();
        tick(1);
        chk_bit(cmd.run, 1'b1);
        rd(ers_pkg::ADDR_COUNT, 16'h0001);
        term_in <= 1'b0;
        tick(1);
        chk_bit(cmd.ramp_down, 1'b1);
        tick(2);
        chk_bit(cmd.override, 1'b0);
        chk_bit(trip_out, 1'b1);
        trip_normal <= 1'b0;
    endtask : t_run
    // Fatal trip stops even in emergency run
    task automatic t_fatal;
        term_in <= 1'b1;
        wait_run(1'b1);
        rd(ers_pkg::ADDR_COUNT, 16'h0002);
        fault_req <= 17'h0_0001;
        tick(4);
        chk_bit(cmd.halt, 1'b1);
        fault_req <= '0;
        term_in <= 1'b0;
        tick(4);
        chk_bit(cmd.halt, 1'b0);
    endtask : t_fatal
    // Test variant: no retry, no tally
    task automatic t_test;
        wr(ers_pkg::ADDR_MODE, 16'h0001);
        term_in <= 1'b1;
        wait_run(1'b1);
        fault_req <= 17'h0_0004;
        tick(4);
        seen = 1'b0;
        for (n = 0; n < 22000; n++) begin
            seen = seen | cmd.run | cmd.reset_pulse;
            tick(1);
        end
        chk_bit(seen, 1'b0);
        rd(ers_pkg::ADDR_COUNT, 16'h0002);
        fault_req <= '0;
        term_in <= 1'b0;
        tick(4);
    endtask : t_test
    // Extended voltage range selection
    task automatic t_ovm;
        wr(ers_pkg::ADDR_VSEL, 16'h0001);
        tick(3);
        chk_bit(ovm_enable, 1'b1);
        hv_req <= 1'b1;
        tick(3);
        chk_bit(ovm_enable, 1'b0);
        hv_req <= 1'b0;
        wr(ers_pkg::ADDR_VSEL, 16'h0000);
        tick(3);
        chk_bit(ovm_enable, 1'b0);
    endtask : t_ovm
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        t_regs();
        t_run();
        t_fatal();
        t_test();
        t_ovm();
        end_of_test();
    end
endmodule : tb_emergency_run_supervisor
